// [design/urg_pkg.sv]
// package of the baud rate generator: register map, field positions,
// reset values, prescale terminals and the state record of the top.
// assumes a 32-bit apb with byte addresses and one word per register.
package urg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFF_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] OFF_DIVISOR_HIGH = 8'h0c;
  localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h10;

  // ----------------------------------------------------------------
  // baud_control fields
  // ----------------------------------------------------------------
  localparam int BAUD_AUTOBAUD_OVERFLOW = 7;
  localparam int BAUD_RECEIVE_IDLE = 6;
  localparam int BAUD_CLOCK_POLARITY = 4;
  localparam int BAUD_WIDE_DIVIDER_SELECT = 3;
  localparam int BAUD_WAKE_ENABLE = 1;
  localparam int BAUD_AUTOBAUD_ENABLE = 0;
  localparam logic [7:0] BAUD_WRITE_MASK = 8'h1b;
  localparam logic [7:0] BAUD_RESET = 8'h40;

  // ----------------------------------------------------------------
  // transmit_status_control fields
  // ----------------------------------------------------------------
  localparam int TX_CLOCK_SOURCE = 7;
  localparam int TX_NINE_BIT = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC_MODE = 4;
  localparam int TX_SEND_BREAK = 3;
  localparam int TX_HIGH_SPEED_SELECT = 2;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam logic [7:0] TX_WRITE_MASK = 8'hfd;
  localparam logic [7:0] TX_RESET = 8'h02;

  // ----------------------------------------------------------------
  // receive_status_control fields
  // ----------------------------------------------------------------
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_NINE_BIT = 6;
  localparam int RX_SINGLE_RECEIVE = 5;
  localparam int RX_CONTINUOUS_RECEIVE = 4;
  localparam int RX_ADDRESS_DETECT = 3;
  localparam int RX_FRAMING_ERROR = 2;
  localparam int RX_OVERRUN_ERROR = 1;
  localparam int RX_NINTH_BIT = 0;
  localparam logic [7:0] RX_WRITE_MASK = 8'hf8;
  localparam logic [7:0] RX_RESET = 8'h00;

  localparam logic [7:0] DIVISOR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // prescale terminals: the prescaler counts 0..last, so it
  // divides by last+1 (64, 16 or 4)
  // ----------------------------------------------------------------
  localparam int PRESCALE_WIDTH = 6;
  localparam logic [5:0] PRESCALE_LAST_64 = 6'h3f;
  localparam logic [5:0] PRESCALE_LAST_16 = 6'h0f;
  localparam logic [5:0] PRESCALE_LAST_4 = 6'h03;

  typedef struct packed {
    logic [7:0] baud_control;
    logic [7:0] transmit_control;
    logic [7:0] receive_control;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [31:0] read_data;
    logic rate_tick;
  } urg_state_type;

endpackage

// [design/urg_counter.sv]
// up counter that wraps to zero once it reaches a limit.
// assumes advance and clear come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module urg_counter #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic advance,
  input wire logic [WIDTH-1:0] limit,
  output logic wrap
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } urg_counter_state_type;

  urg_counter_state_type state;
  urg_counter_state_type next_state;

  generate
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("urg_counter width must be 1 to 32");
    end
  endgenerate

  // greater-or-equal so a smaller limit written mid-count still wraps
  assign wrap = advance & (state.count >= limit);

  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.count = '0;
    end else if (wrap) begin
      next_state.count = '0;
    end else if (advance) begin
      next_state.count = state.count + WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// [design/urg_idle_flag.sv]
// receive idle flag: high while the receiver waits for a start bit.
// assumes start and done are one-cycle pulses on pclk from the receiver.
`timescale 1ns/1ps
`default_nettype none
module urg_idle_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic start,
  input wire logic done,
  output logic idle
);

  typedef struct packed {
    logic idle;
  } urg_idle_state_type;

  urg_idle_state_type state;
  urg_idle_state_type next_state;

  assign idle = state.idle;

  // a start in the same cycle as a done opens the next frame
  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state.idle = 1'b1;
    end else if (start) begin
      next_state.idle = 1'b0; // [RQ12]
    end else if (done) begin
      next_state.idle = 1'b1; // [RQ12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{idle: 1'b1};
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// [design/urg_top.sv]
// baud rate generator of the serial port with its apb register file.
// assumes the transmit and receive shift logic run on pclk and take
// rate_tick as their bit-rate timing; their status arrives here as
// same-clock levels and pulses, so no synchronisers are needed.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RQ1] one rate timer, 8 or 16 bits
// [RQ2] 8-bit after reset; wide select gives 16
// [RQ3] divisor pair n sets free-running period
// [RQ4] async multiplier from high-speed and wide bits
// [RQ5] sync mode ignores high-speed select
// [RQ6] divisor write clears the timer at once
// [RQ7] async 8-bit low speed: clock/(64(n+1))
// [RQ8] async 16-bit low speed: clock/(16(n+1))
// [RQ9] sync 8-bit: clock/(4(n+1))
// [RQ10] other modes divide by 16 or 4
// [RQ11] software checks idle before clock change
// [RQ12] idle flag high until start bit seen
module urg_top #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_shift_empty,
  input wire logic tx_break_done,
  input wire logic rx_start,
  input wire logic rx_done,
  input wire logic rx_single_done,
  input wire logic rx_framing_error,
  input wire logic rx_overrun_error,
  input wire logic rx_ninth_bit,
  input wire logic autobaud_overflow,
  input wire logic autobaud_done,
  input wire logic wake_done,
  output logic rate_tick,
  output logic [7:0] baud_mode,
  output logic [7:0] transmit_mode,
  output logic [7:0] receive_mode
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
      $error("urg_top address width must be 8 to 32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  urg_pkg::urg_state_type state;
  urg_pkg::urg_state_type next_state;

  logic setup_phase;
  logic access_phase;
  logic write_strobe;
  logic [7:0] word_addr;
  logic addr_aligned;
  logic hit_baud;
  logic hit_receive;
  logic hit_low;
  logic hit_high;
  logic hit_transmit;
  logic hit_any;
  logic [7:0] write_byte;

  logic port_enable;
  logic sync_mode;
  logic high_speed;
  logic wide_divider;
  logic receive_idle;
  logic clear_timer;
  logic [urg_pkg::PRESCALE_WIDTH-1:0] prescale_last;
  logic [15:0] divisor_value;
  logic prescale_wrap;
  logic timer_wrap;

  logic [7:0] baud_view;
  logic [7:0] receive_view;
  logic [7:0] transmit_view;
  logic [7:0] read_byte;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // the read word is captured in the setup cycle so prdata comes from
  // a flop; the access cycle then completes at once with pready high.
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign write_strobe = access_phase & pwrite & hit_any;
  assign word_addr = paddr[7:0];
  // bits above the map must be zero, so aliases answer as unmapped;
  // an 8-bit bus has no such bits and a reversed select would not build
  generate
    if (ADDR_WIDTH > 8) begin : g_upper_addr
      assign addr_aligned = (paddr[ADDR_WIDTH-1:8] == '0);
    end else begin : g_no_upper_addr
      assign addr_aligned = 1'b1;
    end
  endgenerate
  assign hit_baud = addr_aligned & (word_addr == urg_pkg::OFF_BAUD_CONTROL);
  assign hit_receive = addr_aligned & (word_addr == urg_pkg::OFF_RECEIVE_STATUS_CONTROL);
  assign hit_low = addr_aligned & (word_addr == urg_pkg::OFF_DIVISOR_LOW);
  assign hit_high = addr_aligned & (word_addr == urg_pkg::OFF_DIVISOR_HIGH);
  assign hit_transmit = addr_aligned & (word_addr == urg_pkg::OFF_TRANSMIT_STATUS_CONTROL);
  assign hit_any = hit_baud | hit_receive | hit_low | hit_high | hit_transmit;
  assign write_byte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;
  assign prdata = state.read_data;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign port_enable = state.receive_control[urg_pkg::RX_PORT_ENABLE];
  assign sync_mode = state.transmit_control[urg_pkg::TX_SYNC_MODE];
  assign high_speed = state.transmit_control[urg_pkg::TX_HIGH_SPEED_SELECT];
  assign wide_divider = state.baud_control[urg_pkg::BAUD_WIDE_DIVIDER_SELECT]; // [RQ2]

  // in 8-bit mode only the low byte counts; the high byte is kept
  always_comb begin
    if (wide_divider) begin
      divisor_value = {state.divisor_high, state.divisor_low}; // [RQ1] [RQ3]
    end else begin
      divisor_value = {8'h00, state.divisor_low}; // [RQ1] [RQ2]
    end
  end

  // divide factor: the prescaler supplies 64, 16 or 4
  always_comb begin
    if (sync_mode) begin
      prescale_last = urg_pkg::PRESCALE_LAST_4; // [RQ5] [RQ9] [RQ10]
    end else begin
      unique case ({wide_divider, high_speed}) // [RQ4]
        2'b00: prescale_last = urg_pkg::PRESCALE_LAST_64; // [RQ7]
        2'b01: prescale_last = urg_pkg::PRESCALE_LAST_16; // [RQ10]
        2'b10: prescale_last = urg_pkg::PRESCALE_LAST_16; // [RQ8]
        2'b11: prescale_last = urg_pkg::PRESCALE_LAST_4; // [RQ10]
      endcase
    end
  end

  // a disabled port holds the timer cleared, as in reset
  assign clear_timer = (write_strobe & (hit_low | hit_high)) | ~port_enable; // [RQ6]

  // ----------------------------------------------------------------
  // rate timer
  // ----------------------------------------------------------------
  // period = (prescale_last+1) * (n+1) clocks; the timer runs free and
  // restarts from zero after every wrap.
  urg_counter #(
    .WIDTH(urg_pkg::PRESCALE_WIDTH)
  ) u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clear_timer),
    .advance(1'b1),
    .limit(prescale_last),
    .wrap(prescale_wrap)
  );

  urg_counter #(
    .WIDTH(16)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clear_timer),
    .advance(prescale_wrap),
    .limit(divisor_value),
    .wrap(timer_wrap)
  );

  assign rate_tick = state.rate_tick;

  // ----------------------------------------------------------------
  // receive idle flag
  // ----------------------------------------------------------------
  urg_idle_flag u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .enable(port_enable),
    .start(rx_start),
    .done(rx_done),
    .idle(receive_idle)
  );

  // ----------------------------------------------------------------
  // read views: stored bits merged with live status
  // ----------------------------------------------------------------
  always_comb begin
    baud_view = state.baud_control & urg_pkg::BAUD_WRITE_MASK;
    baud_view[urg_pkg::BAUD_AUTOBAUD_OVERFLOW] = autobaud_overflow;
    baud_view[urg_pkg::BAUD_RECEIVE_IDLE] = receive_idle; // [RQ12] [RQ11]
  end

  always_comb begin
    receive_view = state.receive_control & urg_pkg::RX_WRITE_MASK;
    receive_view[urg_pkg::RX_FRAMING_ERROR] = rx_framing_error;
    receive_view[urg_pkg::RX_OVERRUN_ERROR] = rx_overrun_error;
    receive_view[urg_pkg::RX_NINTH_BIT] = rx_ninth_bit;
  end

  always_comb begin
    transmit_view = state.transmit_control & urg_pkg::TX_WRITE_MASK;
    transmit_view[urg_pkg::TX_SHIFT_EMPTY] = tx_shift_empty;
  end

  always_comb begin
    read_byte = 8'h00;
    if (hit_baud) begin
      read_byte = baud_view;
    end else if (hit_receive) begin
      read_byte = receive_view;
    end else if (hit_low) begin
      read_byte = state.divisor_low;
    end else if (hit_high) begin
      read_byte = state.divisor_high;
    end else if (hit_transmit) begin
      read_byte = transmit_view;
    end
  end

  // ----------------------------------------------------------------
  // mode outputs to the shift logic
  // ----------------------------------------------------------------
  assign baud_mode = baud_view;
  assign transmit_mode = transmit_view;
  assign receive_mode = receive_view;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // self-clearing bits drop on the completion pulse, but a software
  // write in the same cycle is newer and wins.
  always_comb begin
    next_state = state;
    next_state.rate_tick = prescale_wrap & timer_wrap & ~clear_timer; // [RQ3]

    if (tx_break_done) begin
      next_state.transmit_control[urg_pkg::TX_SEND_BREAK] = 1'b0;
    end
    if (rx_single_done) begin
      next_state.receive_control[urg_pkg::RX_SINGLE_RECEIVE] = 1'b0;
    end
    if (autobaud_done) begin
      next_state.baud_control[urg_pkg::BAUD_AUTOBAUD_ENABLE] = 1'b0;
    end
    if (wake_done) begin
      next_state.baud_control[urg_pkg::BAUD_WAKE_ENABLE] = 1'b0;
    end

    if (setup_phase) begin
      next_state.read_data = {24'h000000, read_byte};
    end

    if (write_strobe) begin
      if (hit_baud) begin
        next_state.baud_control = write_byte & urg_pkg::BAUD_WRITE_MASK; // [RQ2]
      end
      if (hit_receive) begin
        next_state.receive_control = write_byte & urg_pkg::RX_WRITE_MASK;
      end
      if (hit_low) begin
        next_state.divisor_low = write_byte; // [RQ3]
      end
      if (hit_high) begin
        next_state.divisor_high = write_byte; // [RQ3]
      end
      if (hit_transmit) begin
        next_state.transmit_control = write_byte & urg_pkg::TX_WRITE_MASK; // [RQ4]
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.baud_control <= urg_pkg::BAUD_RESET & urg_pkg::BAUD_WRITE_MASK;
      state.transmit_control <= urg_pkg::TX_RESET & urg_pkg::TX_WRITE_MASK;
      state.receive_control <= urg_pkg::RX_RESET;
      state.divisor_low <= urg_pkg::DIVISOR_RESET;
      state.divisor_high <= urg_pkg::DIVISOR_RESET;
      state.read_data <= 32'h00000000;
      state.rate_tick <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// [test/urg_top_sva.sv]
// checker of the baud rate generator: tick spacing per mode, clears.
// assumes it is bound into urg_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module urg_top_sva #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_start,
  input wire logic rate_tick,
  input wire logic [7:0] baud_mode,
  input wire logic [7:0] transmit_mode,
  input wire logic [7:0] receive_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic div_wr;
  logic [15:0] div;
  logic [3:0] mode;
  logic ok;
  int cnt;
  int p;
  int exp_len;
  assign div_wr = psel && penable && pwrite && (paddr == 8'h08 || paddr == 8'h0c);
  // ----------------------------------------------------------------
  // helper: mode as seen one edge back, since a tick reflects it
  // ----------------------------------------------------------------
  always_comb begin
    if (mode[2]) p = 4;
    else if (mode[1]) p = mode[0] ? 4 : 16;
    else p = mode[0] ? 16 : 64;
    exp_len = p * (int'(mode[1] ? div : {8'h00, div[7:0]}) + 1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 16'h0000;
      mode <= 4'h0;
      ok <= 1'b0;
      cnt <= 0;
    end else begin
      mode <= {receive_mode[7], transmit_mode[4], baud_mode[3], transmit_mode[2]};
      cnt <= rate_tick ? 1 : cnt + 1;
      // a mode change leaves one irregular period, so spacing is not judged
      if (mode != {receive_mode[7], transmit_mode[4], baud_mode[3], transmit_mode[2]}) ok <= 1'b0;
      if (div_wr) begin
        cnt <= 0;
        ok <= 1'b1;
        if (paddr == 8'h08) div[7:0] <= pwdata[7:0];
        else div[15:8] <= pwdata[7:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  period_async8_a: assert property (rate_tick && ok && mode[2:0] == 3'h0 |-> cnt == exp_len)
    else $error("async 8-bit tick spacing wrong");
  period_async16_a: assert property (rate_tick && ok && mode[2:0] == 3'h2 |-> cnt == exp_len)
    else $error("async 16-bit tick spacing wrong");
  period_sync_a: assert property (rate_tick && ok && mode[2] |-> cnt == exp_len)
    else $error("sync tick spacing wrong");
  period_fast_a: assert property (rate_tick && ok && !mode[2] && mode[0] |-> cnt == exp_len)
    else $error("high speed tick spacing wrong");
  tick_single_a: assert property (rate_tick |=> !rate_tick) else $error("tick longer than one cycle");
  div_clear_a: assert property (div_wr |=> !rate_tick [*3]) else $error("tick soon after divisor write");
  tick_gated_a: assert property (!receive_mode[7] && !$past(receive_mode[7]) |-> !rate_tick)
    else $error("tick while port disabled");
  idle_start_a: assert property (rx_start && receive_mode[7] ##1 receive_mode[7] |-> !baud_mode[6])
    else $error("idle flag kept after start bit");
  idle_reset_a: assert property (!$past(presetn) |-> baud_mode[6] && !baud_mode[3])
    else $error("wrong mode bits after reset");
  cover property (rate_tick && ok && mode[2]);
  cover property (rate_tick && ok && mode[2:0] == 3'h0);
  cover property (rx_start && receive_mode[7]);
endmodule
bind urg_top urg_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) urg_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_start(rx_start), .rate_tick(rate_tick),
  .baud_mode(baud_mode), .transmit_mode(transmit_mode), .receive_mode(receive_mode));
`default_nettype wire

// [test/urg_port_model.sv]
// far-side model: receive shift logic timed by rate_tick.
// assumes frame_req is a one-cycle pulse from the bench on pclk.
`timescale 1ns/1ps
`default_nettype none
module urg_port_model #(
  parameter int FRAME_TICKS = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rate_tick,
  input wire logic frame_req,
  output logic rx_start,
  output logic rx_done,
  output logic rx_single_done,
  output logic rx_ninth_bit,
  output logic rx_framing_error,
  output logic tx_shift_empty
);
  int ticks;
  logic busy;
  assign tx_shift_empty = !busy;
  assign rx_framing_error = 1'b0;
  assign rx_single_done = rx_done;
  // a frame lasts a fixed count of bit ticks, so a slow rate stretches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      ticks <= 0;
      rx_start <= 1'b0;
      rx_done <= 1'b0;
      rx_ninth_bit <= 1'b0;
    end else begin
      rx_start <= frame_req && !busy;
      rx_done <= 1'b0;
      if (frame_req && !busy) begin
        busy <= 1'b1;
        ticks <= 0;
      end else if (busy && rate_tick) begin
        ticks <= ticks + 1;
        if (ticks == FRAME_TICKS - 1) begin
          busy <= 1'b0;
          rx_done <= 1'b1;
          rx_ninth_bit <= !rx_ninth_bit;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// testbench of the baud rate generator: reset values, tick spacing
// in every mode, idle flag over a frame, port disable.
// assumes zero-wait apb on urg_top and the port model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic frame_req = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rate_tick, rx_start, rx_done, rx_single_done, rx_ninth_bit, rx_framing_error;
  logic tx_shift_empty;
  logic [7:0] baud_mode, transmit_mode, receive_mode;
  int n_mismatch = 0;
  int checks_done = 0;
  int k, len;
  logic [31:0] rst_exp [5] = '{32'h40, 32'h00, 32'h00, 32'h00, 32'h02};
  // columns: sync, wide, high speed, divisor high, divisor low, multiplier
  int tab [6][6] = '{'{0, 0, 0, 7, 2, 64},
                     '{0, 1, 0, 1, 3, 16},
                     '{1, 0, 1, 0, 5, 4},
                     '{0, 0, 1, 0, 3, 16},
                     '{0, 1, 1, 0, 4, 4},
                     '{1, 1, 1, 1, 0, 4}};
  initial forever #10 pclk = ~pclk;
  urg_top urg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_shift_empty(tx_shift_empty),
    .tx_break_done(1'b0), .rx_start(rx_start), .rx_done(rx_done), .rx_single_done(rx_single_done),
    .rx_framing_error(rx_framing_error), .rx_overrun_error(1'b0), .rx_ninth_bit(rx_ninth_bit),
    .autobaud_overflow(1'b0), .autobaud_done(1'b0), .wake_done(1'b0), .rate_tick(rate_tick),
    .baud_mode(baud_mode), .transmit_mode(transmit_mode), .receive_mode(receive_mode));
  urg_port_model urg_port_model_i (.pclk(pclk), .presetn(presetn), .rate_tick(rate_tick), .frame_req(frame_req),
    .rx_start(rx_start), .rx_done(rx_done), .rx_single_done(rx_single_done), .rx_ninth_bit(rx_ninth_bit),
    .rx_framing_error(rx_framing_error), .tx_shift_empty(tx_shift_empty));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic timed_out();
    n_mismatch++;
    $display("CHECK FAILED wait expected answer seen none");
    report_and_stop();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // entered just after a rising edge; returns one edge after the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 1000);
    if (i >= 1000) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (rate_tick !== 1'b1 && n < 20000);
    if (n >= 20000) timed_out();
    @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 5; r++) begin
      apb(1'b0, 8'(4 * r), 32'h0);
      chk("reset value", rst_exp[r], rd);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped read", 32'h1, {rd[30:0], err});
    $display("test reset done");
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, 8'h04, 32'h80);
      apb(1'b1, 8'h10, 32'(tab[m][0] * 16 + tab[m][2] * 4));
      apb(1'b1, 8'h00, 32'(tab[m][1] * 8));
      apb(1'b1, 8'h0c, 32'(tab[m][3]));
      apb(1'b1, 8'h08, 32'(tab[m][4]));
      len = tab[m][5] * ((tab[m][1] != 0 ? tab[m][3] * 256 : 0) + tab[m][4] + 1);
      wait_tick(k);
      // the count starts one edge after the clearing write, so the tick lands on len
      chk("first tick delay", 32'(len), 32'(k));
      wait_tick(k);
      chk("tick period", 32'(len), 32'(k));
      apb(1'b0, 8'h08, 32'h0);
      chk("divisor_low", 32'(tab[m][4]), rd);
    end
    $display("test modes done");
    apb(1'b1, 8'h0c, 32'h0);
    frame_req <= 1'b1;
    @(posedge pclk);
    frame_req <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("idle during frame", 32'h0, {31'h0, rd[6]});
    k = 0;
    while (rx_done !== 1'b1 && k < 1000) begin
      @(negedge pclk);
      k++;
    end
    if (k >= 1000) timed_out();
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("idle after frame", 32'h1, {31'h0, rd[6]});
    $display("test idle done");
    apb(1'b1, 8'h04, 32'h0);
    k = 0;
    repeat (200) begin
      @(negedge pclk);
      if (rate_tick === 1'b1) k++;
    end
    chk("ticks while disabled", 32'h0, 32'(k));
    $display("test disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
